/* File: inc/dac_load_pkg.sv */
// Constants and carrier types for the host controller of the dual
// byte-loaded converter interface.
// Assumes one 100 MHz clock and a converter wired to the pin bundle.
//
// Contract
// - both address low loads channel A low byte.
// - address 01 loads channel A high nibble.
// - address 10 loads channel B low byte.
// - address 11 loads channel B high nibble.
// - transfer strobe low copies both input latches.
// - all strobes low makes latches transparent.
package dac_load_pkg;

    // -------------------------------------------------------------
    // Widths and field positions
    // -------------------------------------------------------------
    localparam int CODE_W = 12;
    localparam int BUS_W = 8;
    localparam int LOW_HI = 7;
    localparam int HIGH_LO = 8;
    localparam int HIGH_HI = 11;
    localparam int NIB_HI = 3;

    // -------------------------------------------------------------
    // Timing: each strobe phase lasts this long, rounded up to cycles.
    // -------------------------------------------------------------
    localparam int PHASE_NS = 50;
    localparam int CLK_NS = 10;
    localparam int PHASE_CYC = (PHASE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0] PHASE_LAST = 4'(PHASE_CYC - 1);

    // Address encodings of the four input latch halves.
    localparam logic [1:0] ADR_A_LOW = 2'h0;
    localparam logic [1:0] ADR_A_HIGH = 2'h1;
    localparam logic [1:0] ADR_B_LOW = 2'h2;
    localparam logic [1:0] ADR_B_HIGH = 2'h3;

    // Pins driven toward the converter; strobes active low.
    typedef struct packed {
        logic clear_n;
        logic transfer_strobe_n;
        logic select_n;
        logic write_n;
        logic channel_pick_bit;
        logic byte_half_bit;
        logic [7:0] data;
    } pins_t;

    // Pin levels at rest: everything released, bus zero.
    localparam pins_t PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 8'h00};

    // Controller states, one-hot.
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_WRITE = 6'h02,
        ST_GAP = 6'h04,
        ST_XFER = 6'h08,
        ST_CLEAR = 6'h10,
        ST_DONE = 6'h20
    } state_t;

endpackage

/* File: design/dac_load_host.sv */
// Host-side controller that loads two 12-bit codes into the converter
// as four byte writes, then pulses the transfer strobe.
// Assumes pins are sampled by the converter asynchronously to this clock.
`timescale 1ns/1ps
module dac_load_host
(
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic clear_i,
    input wire logic [11:0] code_a_i,
    input wire logic [11:0] code_b_i,
    output logic ready_o,
    output logic done_o,
    output dac_load_pkg::pins_t pins_o
);

    // -------------------------------------------------------------
    // State
    // -------------------------------------------------------------
    dac_load_pkg::state_t state_r, state_nxt; // Sequencer state.
    logic [1:0] step_r, step_nxt; // Which latch half is being written.
    logic [3:0] cnt_r, cnt_nxt; // Cycles spent in the current phase.
    logic [23:0] codes_r, codes_nxt; // Captured codes, B above A.
    dac_load_pkg::pins_t pins_r, pins_nxt; // Registered pin levels.
    logic done_r, done_nxt; // One-cycle completion pulse.

    // Picks the data byte for a given latch half.
    function automatic logic [7:0] byte_for(input logic [1:0] adr, input logic [23:0] c);
        logic [11:0] code;
        // The upper code of the pair belongs to channel B.
        if (adr[1])
            code = c[2 * dac_load_pkg::CODE_W - 1:dac_load_pkg::CODE_W];
        else
            code = c[dac_load_pkg::CODE_W - 1:0];
        if (adr[0])
            byte_for = {4'h0, code[dac_load_pkg::HIGH_HI:dac_load_pkg::HIGH_LO]};
        else
            byte_for = code[dac_load_pkg::LOW_HI:0];
    endfunction

    // -------------------------------------------------------------
    // Next-state logic
    // -------------------------------------------------------------
    // The strobes are held for whole phases, with address and data set on the edge they fall
    // and steady until after they rise, since the converter latches are level-driven.
    always_comb
    begin
        state_nxt = state_r;
        step_nxt = step_r;
        cnt_nxt = cnt_r + 4'h1;
        codes_nxt = codes_r;
        pins_nxt = pins_r;
        done_nxt = 1'b0;
        case (state_r)
            dac_load_pkg::ST_IDLE:
            begin
                cnt_nxt = 4'h0;
                pins_nxt = dac_load_pkg::PINS_IDLE;
                if (clear_i)
                begin
                    // Clear beats loading; every latch goes to zero.
                    pins_nxt.clear_n = 1'b0;
                    state_nxt = dac_load_pkg::ST_CLEAR;
                end
                else if (start_i)
                begin
                    codes_nxt = {code_b_i, code_a_i};
                    step_nxt = dac_load_pkg::ADR_A_LOW;
                    pins_nxt.select_n = 1'b0;
                    pins_nxt.write_n = 1'b0;
                    pins_nxt.channel_pick_bit = 1'b0;
                    pins_nxt.byte_half_bit = 1'b0;
                    pins_nxt.data = byte_for(dac_load_pkg::ADR_A_LOW, {code_b_i, code_a_i});
                    state_nxt = dac_load_pkg::ST_WRITE;
                end
            end
            dac_load_pkg::ST_WRITE:
            begin
                // Address bits choose the half: 00 A low, 01 A high,
                // 10 B low, 11 B high.
                if (cnt_r == dac_load_pkg::PHASE_LAST)
                begin
                    cnt_nxt = 4'h0;
                    pins_nxt.write_n = 1'b1;
                    pins_nxt.select_n = 1'b1;
                    state_nxt = dac_load_pkg::ST_GAP;
                end
            end
            dac_load_pkg::ST_GAP:
            begin
                // Strobes released, latches hold; the address moves only as the strobes fall again.
                if (cnt_r == dac_load_pkg::PHASE_LAST)
                begin
                    cnt_nxt = 4'h0;
                    if (step_r == dac_load_pkg::ADR_B_HIGH)
                    begin
                        // Select high, write and transfer low: copy both.
                        pins_nxt.write_n = 1'b0;
                        pins_nxt.transfer_strobe_n = 1'b0;
                        state_nxt = dac_load_pkg::ST_XFER;
                    end
                    else
                    begin
                        step_nxt = step_r + 2'h1;
                        pins_nxt.channel_pick_bit = step_nxt[1];
                        pins_nxt.byte_half_bit = step_nxt[0];
                        pins_nxt.data = byte_for(step_nxt, codes_r);
                        pins_nxt.select_n = 1'b0;
                        pins_nxt.write_n = 1'b0;
                        state_nxt = dac_load_pkg::ST_WRITE;
                    end
                end
            end
            dac_load_pkg::ST_XFER:
            begin
                // Select stays high so the latches are never transparent;
                // the host never uses the all-low mode.
                if (cnt_r == dac_load_pkg::PHASE_LAST)
                begin
                    pins_nxt = dac_load_pkg::PINS_IDLE;
                    state_nxt = dac_load_pkg::ST_DONE;
                end
            end
            dac_load_pkg::ST_CLEAR:
            begin
                if (cnt_r == dac_load_pkg::PHASE_LAST)
                begin
                    pins_nxt = dac_load_pkg::PINS_IDLE;
                    state_nxt = dac_load_pkg::ST_DONE;
                end
            end
            dac_load_pkg::ST_DONE:
            begin
                done_nxt = 1'b1;
                state_nxt = dac_load_pkg::ST_IDLE;
            end
            default:
            begin
                pins_nxt = dac_load_pkg::PINS_IDLE;
                state_nxt = dac_load_pkg::ST_IDLE;
            end
        endcase
    end

    // -------------------------------------------------------------
    // Registers
    // -------------------------------------------------------------
    // Reset parks the pins released so the converter holds its codes.
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_r <= dac_load_pkg::ST_IDLE;
            step_r <= 2'h0;
            cnt_r <= 4'h0;
            codes_r <= 24'h000000;
            pins_r <= dac_load_pkg::PINS_IDLE;
            done_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            step_r <= step_nxt;
            cnt_r <= cnt_nxt;
            codes_r <= codes_nxt;
            pins_r <= pins_nxt;
            done_r <= done_nxt;
        end
    end

    assign ready_o = (state_r == dac_load_pkg::ST_IDLE);
    assign done_o = done_r;
    assign pins_o = pins_r;

    // -------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------
    property p_low_a;
        @(posedge clock_i) disable iff (rst_i)
        (ready_o && start_i && !clear_i) |=> (!pins_o.select_n && !pins_o.write_n
            && pins_o.channel_pick_bit == 1'b0 && pins_o.byte_half_bit == 1'b0
            && pins_o.data == $past(code_a_i[7:0]));
    endproperty
    a_low_a: assert property (p_low_a) else $error("channel A low byte not driven");

    property p_write_len;
        @(posedge clock_i) disable iff (rst_i)
        $fell(pins_o.write_n) && pins_o.transfer_strobe_n |-> !pins_o.write_n [*5] ##1 pins_o.write_n;
    endproperty
    a_write_len: assert property (p_write_len) else $error("write strobe length wrong");

    property p_stable;
        @(posedge clock_i) disable iff (rst_i)
        (!pins_o.write_n && !$fell(pins_o.write_n)) |-> $stable(pins_o.data)
            && $stable(pins_o.channel_pick_bit) && $stable(pins_o.byte_half_bit);
    endproperty
    a_stable: assert property (p_stable) else $error("bus moved under write");

    property p_high_nib;
        @(posedge clock_i) disable iff (rst_i)
        (!pins_o.select_n && pins_o.byte_half_bit) |-> pins_o.data[7:4] == 4'h0;
    endproperty
    a_high_nib: assert property (p_high_nib) else $error("high nibble upper bits set");

    property p_xfer;
        @(posedge clock_i) disable iff (rst_i)
        !pins_o.transfer_strobe_n |-> pins_o.select_n && !pins_o.write_n && pins_o.clear_n;
    endproperty
    a_xfer: assert property (p_xfer) else $error("transfer pins inconsistent");

    property p_no_transp;
        @(posedge clock_i) disable iff (rst_i)
        !(!pins_o.transfer_strobe_n && !pins_o.select_n);
    endproperty
    a_no_transp: assert property (p_no_transp) else $error("transparent mode entered");

    property p_clear;
        @(posedge clock_i) disable iff (rst_i)
        (ready_o && clear_i) |=> !pins_o.clear_n && pins_o.select_n && pins_o.transfer_strobe_n;
    endproperty
    a_clear: assert property (p_clear) else $error("clear not driven");

    property p_done;
        @(posedge clock_i) disable iff (rst_i)
        $fell(pins_o.transfer_strobe_n) |-> ##[5:7] done_o;
    endproperty
    a_done: assert property (p_done) else $error("done late after transfer");

endmodule

/* File: sim/dac_dev_model.sv */
// Behavioural model of the dual converter's byte-loaded latch path.
// Assumes the host drives the whole pin bundle; the model has no clock.
`timescale 1ns/1ps
module dac_dev_model
(
    input wire dac_load_pkg::pins_t pins_i,
    output logic [11:0] out_a_o,
    output logic [11:0] out_b_o
);
    // ------------------------------------------------------------
    // Latches
    // ------------------------------------------------------------
    logic [11:0] in_a; // Channel A input latch.
    logic [11:0] in_b; // Channel B input latch.
    logic load_en; // Select and write both asserted.

    // Re-evaluated on every pin change, so the transparent path follows the bus.
    // The converter latches power up unknown, as the real part does.
    always @(pins_i)
    begin
        load_en = !pins_i.select_n && !pins_i.write_n;
        if (!pins_i.clear_n)
        begin
            // Clear wins over every other strobe.
            in_a = 12'h000;
            in_b = 12'h000;
            out_a_o = 12'h000;
            out_b_o = 12'h000;
        end
        else
        begin
            // With write released nothing below fires, so all latches hold; select released alone still lets transfer copy.
            if (load_en)
            begin
                case ({pins_i.channel_pick_bit, pins_i.byte_half_bit})
                    2'h0: in_a[7:0] = pins_i.data;
                    2'h1: in_a[11:8] = pins_i.data[3:0];
                    2'h2: in_b[7:0] = pins_i.data;
                    default: in_b[11:8] = pins_i.data[3:0];
                endcase
            end
            // Both channels copy together, whatever the address lines show.
            if (!pins_i.transfer_strobe_n && !pins_i.write_n)
            begin
                out_a_o = in_a;
                out_b_o = in_b;
            end
        end
    end
endmodule

/* File: sim/dac_load_host_tb.sv */
// Self-checking bench for the converter load controller.
// Assumes the device model sits on the pin bundle and judges the codes it ends with.
`timescale 1ns/1ps
module dac_load_host_tb;
    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    logic clock_i = 1'b0; // 100 MHz clock.
    logic rst_i = 1'b1; // Asynchronous reset, active high.
    logic start_i = 1'b0; // Load request.
    logic clear_i = 1'b0; // Clear request.
    logic [11:0] code_a_i = 12'h000; // Channel A code.
    logic [11:0] code_b_i = 12'h000; // Channel B code.
    logic ready_o;
    logic done_o;
    dac_load_pkg::pins_t pins_o;
    logic [11:0] out_a; // Converter latch A as the model holds it.
    logic [11:0] out_b; // Converter latch B as the model holds it.
    int fail_count = 0; // Mismatches seen.
    int n_tests = 0; // Comparisons made.
    int cycles = 0; // Cycle counter for the hang guard.

    dac_load_host dac_load_host_inst (.clock_i(clock_i), .rst_i(rst_i), .start_i(start_i),
        .clear_i(clear_i), .code_a_i(code_a_i), .code_b_i(code_b_i), .ready_o(ready_o),
        .done_o(done_o), .pins_o(pins_o));
    dac_dev_model dac_dev_model_inst (.pins_i(pins_o), .out_a_o(out_a), .out_b_o(out_b));

    // Half period of 5 ns.
    always #5 clock_i = ~clock_i;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    // Compares a seen value against the expected one.
    task automatic chk(input logic [13:0] seen, input logic [13:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Prints the verdict and ends the run.
    task automatic stop_test();
        if (fail_count == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Waits a bounded time for the done pulse, then checks it lasts one cycle.
    task automatic wait_done();
        int n;
        n = 0;
        do
        begin
            @(posedge clock_i);
            #1;
            n++;
        end
        while (done_o !== 1'b1 && n < 60);
        chk(done_o, 1'b1);
        @(posedge clock_i);
        #1;
        chk(done_o, 1'b0);
    endtask

    // Raises one request for a single taking edge, with the codes given.
    task automatic request(input logic ld, input logic cl, input logic [11:0] a,
        input logic [11:0] b);
        @(posedge clock_i);
        start_i <= ld;
        clear_i <= cl;
        code_a_i <= a;
        code_b_i <= b;
        @(posedge clock_i);
        start_i <= 1'b0;
        clear_i <= 1'b0;
        wait_done();
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Pins at rest after reset; a clear empties both converter latches.
    task automatic t_reset_clear();
        chk(pins_o, dac_load_pkg::PINS_IDLE);
        chk(ready_o, 1'b1);
        request(1'b0, 1'b1, 12'h000, 12'h000);
        chk(out_a, 12'h000);
        chk(out_b, 12'h000);
    endtask

    // Every nibble differs, so a swapped half or channel shows.
    task automatic t_load_mixed();
        request(1'b1, 1'b0, 12'hABC, 12'h5F3);
        chk(out_a, 12'hABC);
        chk(out_b, 12'h5F3);
        chk(pins_o, dac_load_pkg::PINS_IDLE);
    endtask

    // Start held high: codes changed mid-load are refused until the next take.
    task automatic t_back_to_back();
        @(posedge clock_i);
        start_i <= 1'b1;
        code_a_i <= 12'hFFF;
        code_b_i <= 12'h000;
        @(posedge clock_i);
        code_a_i <= 12'h000;
        code_b_i <= 12'hFFF;
        wait_done();
        chk(out_a, 12'hFFF);
        chk(out_b, 12'h000);
        // Release the request on an edge; the second load is already under way.
        @(posedge clock_i);
        start_i <= 1'b0;
        wait_done();
        chk(out_a, 12'h000);
        chk(out_b, 12'hFFF);
    endtask

    // Clear and start together: clear has priority and zeroes the outputs.
    task automatic t_clear_wins();
        request(1'b1, 1'b1, 12'h123, 12'h456);
        chk(out_a, 12'h000);
        chk(out_b, 12'h000);
    endtask

    // ------------------------------------------------------------
    // Main sequence and hang guard
    // ------------------------------------------------------------
    // Ceiling well above the five loads and clears of the sequence.
    always @(posedge clock_i)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fail_count++;
            stop_test();
        end
    end

    initial
    begin
        repeat (10) @(posedge clock_i);
        rst_i <= 1'b0;
        #1;
        t_reset_clear();
        t_load_mixed();
        t_back_to_back();
        t_clear_wins();
        stop_test();
    end
endmodule
